// >>> core/lp_idle_clock_ctrl.sv
// idle-mode clock controller with its AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lp_idle_consts.svh"

module lp_idle_clock_ctrl (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite slave
    input  wire logic [`ADDR_W-1:0]  awaddr,
    input  wire logic                awvalid,
    output var  logic                awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output var  logic                wready,
    output var  logic [1:0]          bresp,
    output var  logic                bvalid,
    input  wire logic                bready,
    input  wire logic [`ADDR_W-1:0]  araddr,
    input  wire logic                arvalid,
    output var  logic                arready,
    output var  logic [31:0]         rdata,
    output var  logic [1:0]          rresp,
    output var  logic                rvalid,
    input  wire logic                rready,
    // processor core
    input  wire logic                sleep_exec,
    input  wire logic                wake_event,
    // clock tree controls
    output var  logic                cpu_clk_en,
    output var  logic                code_exec_en,
    output var  logic                periph_clk_en,
    output var  logic [1:0]          periph_clk_src,
    output var  logic                primary_osc_en,
    output var  logic                secondary_osc_en,
    output var  lp_idle_pkg::gain_t  amp_gain
);

    // ************************************************************
    // state
    // ************************************************************
    lp_idle_pkg::ctrl_t  ctrl_r;
    lp_idle_pkg::mode_t  mode_r;
    lp_idle_pkg::mode_t  mode_nxt;
    lp_idle_pkg::src_t   src_r;
    lp_idle_pkg::src_t   src_nxt;
    lp_idle_pkg::status_t status;
    logic                primary_osc_timeout_status_r;
    logic                secondary_osc_running_flag_r;
    logic                wake_done;
    logic                wake_start;
    logic                secondary_oscillator_any;

    logic                aw_full_r;
    logic                w_full_r;
    logic [`ADDR_W-1:0]  awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic                aw_full_nxt;
    logic                w_full_nxt;
    logic                bvalid_nxt;
    logic                rvalid_nxt;
    logic                do_write;
    logic                ar_take;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // address and data may arrive in either order; each is held until both are in
    always_comb
    begin
        do_write    = aw_full_r && w_full_r && !bvalid;
        aw_full_nxt = aw_full_r ? !do_write : (awvalid && awready);
        w_full_nxt  = w_full_r  ? !do_write : (wvalid && wready);
        bvalid_nxt  = bvalid ? !bready : do_write;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            awready   <= !aw_full_nxt && !bvalid_nxt;
            wready    <= !w_full_nxt && !bvalid_nxt;
            if (awvalid && awready)
                awaddr_r <= awaddr;
            if (wvalid && wready)
            begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end
        else
        begin
            bvalid <= bvalid_nxt;
            if (do_write)
                bresp <= (awaddr_r == `CTRL_OFFSET || awaddr_r == `STATUS_OFFSET)
                         ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // only software writes reach the control word; mode changes never touch it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_r <= lp_idle_pkg::ctrl_t'(`CTRL_RESET);
        else if (do_write && awaddr_r == `CTRL_OFFSET)
        begin
            ctrl_r         <= lp_idle_pkg::ctrl_t'(apply_strb(ctrl_r, wdata_r, wstrb_r)); // [RULE_07]
            ctrl_r.rsvd_hi <= '0;
            ctrl_r.rsvd_lo <= '0;
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    always_comb
    begin
        ar_take    = arvalid && arready;
        rvalid_nxt = rvalid ? !rready : ar_take;
    end

    always_comb
    begin
        status                            = '0;
        status.amp_gain                   = amp_gain;
        status.clk_src                    = src_r;
        status.mode                       = mode_r;
        status.code_exec_en               = code_exec_en;
        status.cpu_clk_en                 = cpu_clk_en;
        status.periph_clk_en              = periph_clk_en;
        status.secondary_osc_running_flag = secondary_osc_running_flag_r;
        status.primary_osc_timeout_status = primary_osc_timeout_status_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `RESP_OKAY;
        end
        else
        begin
            arready <= !rvalid_nxt && !ar_take;
            rvalid  <= rvalid_nxt;
            if (ar_take)
            begin
                case (araddr)
                    `CTRL_OFFSET:
                    begin
                        rdata <= ctrl_r;
                        rresp <= `RESP_OKAY;
                    end
                    `STATUS_OFFSET:
                    begin
                        rdata <= status;
                        rresp <= `RESP_OKAY;
                    end
                    default:
                    begin
                        rdata <= '0;
                        rresp <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // clock source and power mode
    // ************************************************************
    // selecting the secondary without any secondary enable keeps the running source as it is
    always_comb
    begin
        secondary_oscillator_any = ctrl_r.secondary_osc_force_on
                || ctrl_r.timer_a_secondary_osc_enable
                || ctrl_r.timer_b_secondary_osc_enable
                || ctrl_r.timer_c_secondary_osc_enable;
        src_nxt  = src_r;
        if (mode_r == lp_idle_pkg::RUN)
        begin
            case (ctrl_r.system_clock_select)
                `SCS_PRIMARY:   src_nxt = lp_idle_pkg::SRC_PRIMARY;
                `SCS_SECONDARY: src_nxt = secondary_oscillator_any ? lp_idle_pkg::SRC_SECONDARY : src_r; // [RULE_13]
                default:        src_nxt = lp_idle_pkg::SRC_INTERNAL;
            endcase
        end
    end

    always_comb
    begin
        mode_nxt   = mode_r;
        wake_start = 1'b0;
        case (mode_r)
            lp_idle_pkg::RUN:
            begin
                // idle flavour follows idle_select_bit: set gives idle, clear gives full sleep
                if (sleep_exec)
                    mode_nxt = ctrl_r.idle_select_bit ? lp_idle_pkg::IDLE       // [RULE_02] [RULE_09]
                                                      : lp_idle_pkg::FULL_SLEEP; // [RULE_17]
            end
            lp_idle_pkg::IDLE, lp_idle_pkg::FULL_SLEEP:
            begin
                if (wake_event)
                begin
                    mode_nxt   = lp_idle_pkg::WAKE_WAIT;
                    wake_start = 1'b1;                                          // [RULE_06] [RULE_12]
                end
            end
            lp_idle_pkg::WAKE_WAIT:
            begin
                if (wake_done)
                    mode_nxt = lp_idle_pkg::RUN;
            end
            default:
                mode_nxt = lp_idle_pkg::RUN;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r <= lp_idle_pkg::RUN;
            src_r  <= lp_idle_pkg::SRC_PRIMARY;
        end
        else
        begin
            mode_r <= mode_nxt;
            src_r  <= src_nxt;
        end
    end

    wake_delay_timer u_wake_delay (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (wake_start),
        .done_r  (wake_done)
    );

    // ************************************************************
    // status flags
    // ************************************************************
    // timeout status tracks the primary source, so idle and wake leave it set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            primary_osc_timeout_status_r    <= 1'b1;
            secondary_osc_running_flag_r <= 1'b0;
        end
        else
        begin
            primary_osc_timeout_status_r    <= (src_nxt == lp_idle_pkg::SRC_PRIMARY);   // [RULE_05] [RULE_11]
            secondary_osc_running_flag_r <= (src_nxt == lp_idle_pkg::SRC_SECONDARY); // [RULE_11]
        end
    end

    // ************************************************************
    // clock tree controls
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_clk_en       <= 1'b1;
            code_exec_en     <= 1'b1;
            periph_clk_en    <= 1'b1;
            periph_clk_src   <= lp_idle_pkg::SRC_PRIMARY;
            primary_osc_en   <= 1'b1;
            secondary_osc_en <= 1'b0;
        end
        else
        begin
            // cpu clock returns at the wake event, execution only after the delay
            cpu_clk_en     <= (mode_nxt == lp_idle_pkg::RUN)
                           || (mode_nxt == lp_idle_pkg::WAKE_WAIT);   // [RULE_04] [RULE_08] [RULE_06]
            code_exec_en   <= (mode_nxt == lp_idle_pkg::RUN);         // [RULE_06] [RULE_12]
            periph_clk_en  <= (mode_nxt != lp_idle_pkg::FULL_SLEEP);  // [RULE_04] [RULE_08] [RULE_17]
            periph_clk_src <= src_nxt;                                // [RULE_04] [RULE_08]
            primary_osc_en <= (src_nxt == lp_idle_pkg::SRC_PRIMARY)
                           && (mode_nxt != lp_idle_pkg::FULL_SLEEP);  // [RULE_01] [RULE_11]
            secondary_osc_en <= secondary_oscillator_any
                             || (src_nxt == lp_idle_pkg::SRC_SECONDARY); // [RULE_12]
        end
    end

    crystal_gain_decode u_gain (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .osc_config_select (ctrl_r.osc_config_select),
        .primary_osc_en    (primary_osc_en),
        .amp_gain_r        (amp_gain)
    );

endmodule
`default_nettype wire

// >>> inc/lp_idle_consts.svh
// constants for the low-power idle clock controller
// What this block does
// RULE_01: primary idle keeps primary clock running
// RULE_02: idle bit plus sleep in primary run
// RULE_03: software sets idle, clears select, sleeps
// RULE_04: primary idle: cpu halted, peripherals primary-clocked
// RULE_05: timeout status stays set through primary idle
// RULE_06: wake: cpu on primary, code after delay
// RULE_07: wake leaves idle bit and select alone
// RULE_08: secondary idle: cpu stopped, peripherals secondary-clocked
// RULE_09: idle bit plus sleep in secondary run
// RULE_10: software sets idle, select 01, sleeps
// RULE_11: switch to secondary stops primary, updates flags
// RULE_12: secondary wake keeps oscillator, code after delay
// RULE_13: no secondary enable: keep clock, matching idle
// RULE_14: software starts secondary oscillator before idle
// RULE_15: crystal mode picks low, medium, high gain
// RULE_16: high-gain mode has medium/high power options
// RULE_17: idle bit clear: sleep stops all clocks; the secondary oscillator keeps running if enabled or selected as source
`ifndef LP_IDLE_CONSTS_SVH
`define LP_IDLE_CONSTS_SVH

// ************************************************************
// register map
// ************************************************************
`define ADDR_W          8
`define CTRL_OFFSET     8'h00
`define STATUS_OFFSET   8'h04
`define CTRL_RESET      32'h0000_0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ************************************************************
// clock select and oscillator configuration encodings
// ************************************************************
`define SCS_PRIMARY     2'h0
`define SCS_SECONDARY   2'h1
`define OSC_CFG_LOW     4'h0
`define OSC_CFG_MEDIUM  4'h1
`define OSC_CFG_HIGH_MP 4'h2
`define OSC_CFG_HIGH_HP 4'h3

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS          20
`define WAKE_TO_CODE_DELAY_NS  2000
`define WAKE_TO_CODE_DELAY_CYC \
    ((`WAKE_TO_CODE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W             8

`endif

// >>> inc/lp_idle_pkg.sv
// types for the low-power idle clock controller
package lp_idle_pkg;

    typedef enum logic [1:0] {RUN, IDLE, FULL_SLEEP, WAKE_WAIT} mode_t;

    typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} src_t;

    typedef enum logic [2:0] {GAIN_OFF, GAIN_LOW, GAIN_MEDIUM, GAIN_HIGH_MP, GAIN_HIGH_HP} gain_t;

    typedef struct packed {
        logic [18:0] rsvd_hi;
        logic [3:0]  osc_config_select;
        logic [1:0]  rsvd_lo;
        logic        timer_c_secondary_osc_enable;
        logic        timer_b_secondary_osc_enable;
        logic        timer_a_secondary_osc_enable;
        logic        secondary_osc_force_on;
        logic [1:0]  system_clock_select;
        logic        idle_select_bit;
    } ctrl_t;

    typedef struct packed {
        logic [19:0] rsvd;
        logic [2:0]  amp_gain;
        logic [1:0]  clk_src;
        logic [1:0]  mode;
        logic        code_exec_en;
        logic        cpu_clk_en;
        logic        periph_clk_en;
        logic        secondary_osc_running_flag;
        logic        primary_osc_timeout_status;
    } status_t;

endpackage

// >>> core/crystal_gain_decode.sv
// crystal amplifier gain decoder
`timescale 1ns/1ps
`default_nettype none
`include "lp_idle_consts.svh"

module crystal_gain_decode (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [3:0]         osc_config_select,
    input  wire logic               primary_osc_en,
    output var  lp_idle_pkg::gain_t amp_gain_r
);

    // amplifier is parked whenever the primary oscillator is shut down
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            amp_gain_r <= lp_idle_pkg::GAIN_OFF;
        else if (!primary_osc_en)
            amp_gain_r <= lp_idle_pkg::GAIN_OFF;
        else
        begin
            case (osc_config_select)
                `OSC_CFG_LOW:     amp_gain_r <= lp_idle_pkg::GAIN_LOW;      // [RULE_15]
                `OSC_CFG_MEDIUM:  amp_gain_r <= lp_idle_pkg::GAIN_MEDIUM;   // [RULE_15]
                `OSC_CFG_HIGH_MP: amp_gain_r <= lp_idle_pkg::GAIN_HIGH_MP;  // [RULE_16]
                `OSC_CFG_HIGH_HP: amp_gain_r <= lp_idle_pkg::GAIN_HIGH_HP;  // [RULE_16]
                default:          amp_gain_r <= lp_idle_pkg::GAIN_OFF;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> core/wake_delay_timer.sv
// fixed wake-to-code delay counter
`timescale 1ns/1ps
`default_nettype none
`include "lp_idle_consts.svh"

module wake_delay_timer (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic start,
    output var  logic done_r
);

    localparam logic [`WAKE_CNT_W-1:0] DELAY_CYC = `WAKE_CNT_W'(`WAKE_TO_CODE_DELAY_CYC);
    localparam logic [`WAKE_CNT_W-1:0] ONE       = `WAKE_CNT_W'(1);

    logic [`WAKE_CNT_W-1:0] cnt_r;
    logic                   run_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (start)
            begin
                cnt_r <= DELAY_CYC;
                run_r <= 1'b1;
            end
            else if (run_r)
            begin
                if (cnt_r == ONE)
                begin
                    run_r  <= 1'b0;
                    done_r <= 1'b1;
                end
                else
                    cnt_r <= cnt_r - ONE;
            end
        end
    end

endmodule
`default_nettype wire

// >>> tb/lp_idle_clock_ctrl_assertions.sv
// concurrent checks on the idle-mode clock controller ports
`timescale 1ns/1ps
`default_nettype none

module lp_idle_checker (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               sleep_exec,
    input wire logic               wake_event,
    input wire logic               cpu_clk_en,
    input wire logic               code_exec_en,
    input wire logic               periph_clk_en,
    input wire logic [1:0]         periph_clk_src,
    input wire logic               primary_osc_en,
    input wire logic               secondary_osc_en,
    input wire lp_idle_pkg::gain_t amp_gain
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ************************************************************
    // sequences
    // ************************************************************
    // code_exec_en high only in run, so this is a sleep that is acted on
    sequence s_sleep; sleep_exec && code_exec_en; endsequence
    sequence s_wake; wake_event && !cpu_clk_en; endsequence

    // ************************************************************
    // properties
    // ************************************************************
    property p_sleep_stops_cpu; s_sleep |=> !cpu_clk_en && !code_exec_en; endproperty
    a_sleep_stops_cpu: assert property (p_sleep_stops_cpu)
        else $error("cpu clock still on after sleep");
    property p_primary_idle_mode_osc;
        !cpu_clk_en && periph_clk_en && periph_clk_src == 2'h0 |-> primary_osc_en;
    endproperty
    a_primary_idle_mode_osc: assert property (p_primary_idle_mode_osc)
        else $error("primary oscillator off in primary idle");
    property p_sec_src; periph_clk_src == 2'h1 |-> !primary_osc_en && secondary_osc_en; endproperty
    a_sec_src: assert property (p_sec_src)
        else $error("oscillator enables wrong on secondary source");
    property p_full_sleep; !periph_clk_en |-> !cpu_clk_en && !primary_osc_en; endproperty
    a_full_sleep: assert property (p_full_sleep)
        else $error("clocks left running in full sleep");
    property p_wake_cpu; s_wake |=> cpu_clk_en && !code_exec_en; endproperty
    a_wake_cpu: assert property (p_wake_cpu)
        else $error("cpu clock not restored on wake");
    property p_wake_delay; s_wake |-> ##101 !code_exec_en ##1 code_exec_en; endproperty
    a_wake_delay: assert property (p_wake_delay)
        else $error("wake to code delay wrong");
    property p_wake_src; (s_wake and periph_clk_en) |=> periph_clk_en && $stable(periph_clk_src);
    endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("peripheral clock disturbed by wake");
    property p_gain_off; !primary_osc_en |=> amp_gain == lp_idle_pkg::GAIN_OFF; endproperty
    a_gain_off: assert property (p_gain_off)
        else $error("amplifier gain on with primary oscillator off");
endmodule

bind lp_idle_clock_ctrl lp_idle_checker chk (
    .aclk(aclk), .aresetn(aresetn), .sleep_exec(sleep_exec), .wake_event(wake_event),
    .cpu_clk_en(cpu_clk_en), .code_exec_en(code_exec_en), .periph_clk_en(periph_clk_en),
    .periph_clk_src(periph_clk_src), .primary_osc_en(primary_osc_en),
    .secondary_osc_en(secondary_osc_en), .amp_gain(amp_gain)
);
`default_nettype wire

// >>> tb/core_model.sv
// behavioural processor core issuing sleep and wake events
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic aclk,
    input  wire logic code_exec_en,
    output var  logic sleep_exec,
    output var  logic wake_event
);
    int wake_cycles;

    initial
    begin
        sleep_exec = 1'b0;
        wake_event = 1'b0;
        wake_cycles = 0;
    end

    // a halted core fetches nothing, so sleep waits for code to run
    task automatic do_sleep();
        @(posedge aclk);
        while (!code_exec_en)
            @(posedge aclk);
        sleep_exec <= 1'b1;
        @(posedge aclk);
        sleep_exec <= 1'b0;
    endtask

    // gap lets the wake come promptly or late
    task automatic do_wake(input int gap);
        @(posedge aclk);
        repeat (gap) @(posedge aclk);
        wake_event <= 1'b1;
        @(posedge aclk);
        wake_event <= 1'b0;
        wake_cycles = 0;
        do
        begin
            @(posedge aclk);
            #1;
            wake_cycles++;
        end
        while (!code_exec_en && wake_cycles < 300);
    endtask
endmodule
`default_nettype wire

// >>> tb/low_power_idle_mode_control_test.sv
// register-level test of the idle-mode clock controller
`timescale 1ns/1ps
`default_nettype none
`include "lp_idle_consts.svh"

module low_power_idle_mode_control_test;
    logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready, sleep_exec, wake_event;
    logic               cpu_clk_en, code_exec_en, periph_clk_en, primary_osc_en;
    logic               secondary_osc_en;
    logic [`ADDR_W-1:0] awaddr, araddr;
    logic [31:0]        wdata, rdata, d;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, periph_clk_src, r;
    lp_idle_pkg::gain_t amp_gain;
    lp_idle_pkg::gain_t g_exp [5];
    int                 n_mismatch, compares;

    lp_idle_clock_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .sleep_exec, .wake_event, .cpu_clk_en, .code_exec_en,
        .periph_clk_en, .periph_clk_src, .primary_osc_en, .secondary_osc_en, .amp_gain);
    core_model core (.aclk, .code_exec_en, .sleep_exec, .wake_event);

    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // cpu, code, periph, primary, secondary, source
    task automatic ports(input logic [31:0] exp, input string what);
        chk(32'({cpu_clk_en, code_exec_en, periph_clk_en, primary_osc_en, secondary_osc_en,
            periph_clk_src}), exp, what);
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw_ok, w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid)
            @(posedge aclk);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        while (!rvalid)
            @(posedge aclk);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // source switch and gain decode land a fixed few edges after the write
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask

    task automatic sleep_chk(input logic [31:0] exp);
        core.do_sleep();
        #1;
        ports(exp, "after sleep");
    endtask

    task automatic wake_chk(input int gap, input logic [31:0] ctrl);
        core.do_wake(gap);
        chk(32'(core.wake_cycles), 32'(`WAKE_TO_CODE_DELAY_CYC + 1), "wake delay");
        rd(`CTRL_OFFSET, d, r);
        chk(d, ctrl, "ctrl after wake");
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        g_exp = '{lp_idle_pkg::GAIN_LOW, lp_idle_pkg::GAIN_MEDIUM, lp_idle_pkg::GAIN_HIGH_MP,
            lp_idle_pkg::GAIN_HIGH_HP, lp_idle_pkg::GAIN_OFF};
        n_mismatch = 0;
        compares = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'hF};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        ports(32'h78, "reset ports");
        rd(`CTRL_OFFSET, d, r);
        chk(d, `CTRL_RESET, "ctrl reset");
        rd(`STATUS_OFFSET, d, r);
        chk(d, 32'h0000_021D, "status reset");
        rd(8'h08, d, r);
        chk(d, 32'h0000_0000, "unmapped data");
        chk(32'(r), 32'(`RESP_SLVERR), "unmapped read resp");
        wr(8'h0C, 32'h0000_0000, r);
        chk(32'(r), 32'(`RESP_SLVERR), "unmapped write resp");
        wr(`STATUS_OFFSET, 32'hFFFF_FFFF, r);
        chk(32'(r), 32'(`RESP_OKAY), "status write resp");
        for (int i = 0; i < 5; i++)
        begin
            wr(`CTRL_OFFSET, {19'h00000, 4'(i), 9'h000}, r);
            settle();
            chk(32'(amp_gain), 32'(g_exp[i]), "gain decode");
        end
        wr(`CTRL_OFFSET, 32'h0000_0001, r);
        settle();
        sleep_chk(32'h18);
        rd(`STATUS_OFFSET, d, r);
        chk(32'({d[6:5], d[0]}), 32'h3, "primary idle status");
        wake_chk(0, 32'h0000_0001);
        rd(`STATUS_OFFSET, d, r);
        chk(32'(d[0]), 32'h1, "timeout status after wake");
        wr(`CTRL_OFFSET, 32'h0000_0003, r);
        settle();
        ports(32'h78, "select without enable");
        sleep_chk(32'h18);
        wake_chk(5, 32'h0000_0003);
        for (int i = 3; i < 7; i++)
        begin
            wr(`CTRL_OFFSET, 32'h0000_0001, r);
            settle();
            wr(`CTRL_OFFSET, 32'h0000_0003 | (32'h1 << i), r);
            settle();
            ports(32'h75, "secondary run");
        end
        rd(`STATUS_OFFSET, d, r);
        chk(32'(d[1:0]), 32'h2, "secondary flags");
        sleep_chk(32'h15);
        wake_chk(40, 32'h0000_0043);
        ports(32'h75, "after secondary wake");
        wr(`CTRL_OFFSET, 32'h0000_0005, r);
        settle();
        ports(32'h72, "internal source");
        wr(`CTRL_OFFSET, 32'h0000_0000, r);
        settle();
        sleep_chk(32'h00);
        wake_chk(3, 32'h0000_0000);
        ports(32'h78, "after full sleep wake");
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
